// >>> amp_ctrl_chk.sv
`timescale 1ns/1ns
module amp_ctrl_chk
(
  input logic       sys_clk_i,
  input logic       resetn_i,
  input logic [1:0] speed_mode_i,
  input logic [8:0] left_volume_o,
  input logic [8:0] right_volume_o,
  input logic [9:0] left_gain_half_db_o,
  input logic [9:0] right_gain_half_db_o,
  input logic       left_soft_mute_o,
  input logic       right_soft_mute_o,
  input logic [1:0] deemph_select_o,
  input logic [1:0] deemph_active_o,
  input logic [3:0] channel_mix_select_o,
  input logic [1:0] left_source_o,
  input logic [1:0] right_source_o,
  input logic [4:0] pcomp_o,
  input logic [4:0] ncomp_o,
  input logic       pwm_high_speed_o,
  input logic       pwm_h_type_o,
  input logic [3:0] pwm_mode_o,
  input logic       word_update_o,
  input logic       frame_error_o,
  input logic       link_data_oe_o
);
  default clocking dc @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  property p_mute;
    left_soft_mute_o == (left_volume_o <= 9'h040);
  endproperty
  a_mute: assert property (p_mute) else $error("soft mute flag");
  property p_mute_r;
    right_soft_mute_o == (right_volume_o <= 9'h040);
  endproperty
  a_mute_r: assert property (p_mute_r) else $error("right mute flag");
  property p_gain_l;
    (left_volume_o > 9'h040 && left_volume_o < 9'h130)
      |-> left_gain_half_db_o == {1'b0, left_volume_o} - 10'h0FE;
  endproperty
  a_gain_l: assert property (p_gain_l) else $error("left gain");
  property p_gain_r;
    right_volume_o <= 9'h040 |-> right_gain_half_db_o == 10'h342;
  endproperty
  a_gain_r: assert property (p_gain_r) else $error("right mute gain");
  property p_deemph_off;
    (speed_mode_i != 2'h0)[*2] |-> deemph_active_o == 2'h0;
  endproperty
  a_deemph_off: assert property (p_deemph_off) else $error("deemph on");
  property p_deemph_on;
    (speed_mode_i == 2'h0)[*2] ##0 $stable(deemph_select_o)
      |-> deemph_active_o == deemph_select_o;
  endproperty
  a_deemph_on: assert property (p_deemph_on) else $error("deemph off");
  property p_src;
    left_source_o == channel_mix_select_o[3:2]
      && right_source_o == channel_mix_select_o[1:0];
  endproperty
  a_src: assert property (p_src) else $error("mix sources");
  property p_mode;
    pwm_mode_o == 4'h1 << {pwm_high_speed_o, pwm_h_type_o};
  endproperty
  a_mode: assert property (p_mode) else $error("pwm mode");
  property p_comp;
    pcomp_o <= 5'h10 && ncomp_o <= 5'h10;
  endproperty
  a_comp: assert property (p_comp) else $error("comp range");
  property p_hold;
    !$past(word_update_o) |-> $stable({left_volume_o, pcomp_o, ncomp_o,
      channel_mix_select_o, deemph_select_o});
  endproperty
  a_hold: assert property (p_hold) else $error("field moved");
  property p_err;
    frame_error_o |=> (!word_update_o)[*8];
  endproperty
  a_err: assert property (p_err) else $error("update after error");
  c_upd: cover property (word_update_o);
  c_err: cover property (frame_error_o);
  c_read: cover property ($rose(link_data_oe_o));
endmodule
bind amp_ctrl_regs amp_ctrl_chk u_chk (.*);

// >>> amp_ctrl_defs.vh
`ifndef AMP_CTRL_DEFS_VH
`define AMP_CTRL_DEFS_VH

// Field positions inside the 64-bit control word
`define VOL_W            9
`define VOL_L_LSB        0
`define VOL_R_LSB        9
`define BASS_BOOST_BIT   18
`define BASS_LVL_LSB     19
`define BASS_CORNER_LSB  23
`define TREB_BOOST_BIT   25
`define TREB_LVL_LSB     26
`define TREB_CORNER_LSB  30
`define DEEMPH_LSB       32
`define LIMIT_EN_BIT     34
`define LIMIT_MODE_BIT   35
`define DITHER_BIT       36
`define ATTACK_LSB       37
`define RELEASE_LSB      40
`define FORMAT_LSB       44
`define MIX_LSB          46
`define BRIDGE_BIT       50
`define PCOMP_LSB        51
`define NCOMP_LSB        56
`define LOW_POWER_BIT    61
`define SPEED_BIT        62
`define METHOD_BIT       63

// Reset values and codes
`define VOL_RESET        9'h0FA
`define VOL_0DB          9'h0FE
`define VOL_MAX          9'h130
`define VOL_SOFT_MUTE    9'h040
`define ATTACK_RESET     3'h1
`define RELEASE_RESET    4'hA
`define MIX_RESET        4'h9
`define PCOMP_RESET      5'h10
`define NCOMP_RESET      5'h00
`define COMP_MAX         5'h10
`define SPEED_SINGLE     2'h0
`define CTRL_RESET {3'h0, `NCOMP_RESET, `PCOMP_RESET, 1'b0, `MIX_RESET, \
  2'h0, `RELEASE_RESET, `ATTACK_RESET, 3'h0, 2'h0, 14'h0000, \
  `VOL_RESET, `VOL_RESET}

// Link framing
`define WORD_W           64
`define PRE_W            8
`define PRE_MARK_BIT     5
`define PRE_REF_LSB      1
`define PRE_RW_BIT       0

`endif

// >>> amp_ctrl_regs.v
// What this block does
// RL1: De-emphasis select 00 none, 01 44.1k, 10 32k, 11 48k.
// RL2: De-emphasis filter acts only in single speed mode.
// RL3: Bit 34 turns the clip limiter on or off.
// RL4: Bit 35: 0 cuts bass on bass clip, 1 lowers volume.
// RL5: Attack code bits 37-39, reset value 001.
// RL6: Release code bits 40-43, reset value 1010.
// RL7: Bits 44-45 pick I2S, left, right 16 or right 24 format.
// RL8: Mix field bits 46-49 does mute, mono, swap; resets to 1001.
// RL9: Upper mix pair picks left source, lower pair right source.
// RL10: Bit 50 gates the bridge drive, off after reset.
// RL11: P and N compensation fields, kept within 0 to 16.
// RL12: Bit 61 enables automatic low power.
// RL13: Bit 62 speed, bit 63 H-type or R-type method.
// RL14: Speed and method map to four PWM operating modes.
// RL15: Volume code steps 0.5 dB, 0FE is 0 dB, 130 is +25 dB.
// RL16: Code 040 is soft mute at -95 dB; reset code 0FA.
// RL17: Left volume bits 0-8, right bits 9-17, same mapping.
// RL18: Host should step volume through every 0.5 dB code.
// RL19: Bass level bits 19-22 in 1 dB, bit 18 boost or cut.
// RL20: Bass corner bits 23-24: 50, 100 or 200 Hz.
// RL21: Treble level bits 26-29 in 1 dB, bit 25 boost or cut.
// RL22: Treble corner bits 30-31: 4, 8 or 12 kHz.
// RL23: Fields change only after a whole serial word arrives.
`timescale 1ns/1ns
`include "amp_ctrl_defs.vh"
module amp_ctrl_regs
#(
  // Arbitrary silicon reference expected in the preamble
  parameter [3:0] PART_REF = 4'h5
)
(
  input  wire       sys_clk_i,
  input  wire       resetn_i,
  input  wire       link_en_n_i,
  input  wire       link_clk_i,
  input  wire       link_data_i,
  output reg        link_data_o,
  output reg        link_data_oe_o,
  input  wire [1:0] speed_mode_i,
  output reg  [8:0] left_volume_o,
  output reg  [8:0] right_volume_o,
  output reg  [9:0] left_gain_half_db_o,
  output reg  [9:0] right_gain_half_db_o,
  output reg        left_soft_mute_o,
  output reg        right_soft_mute_o,
  output reg        bass_boost_select_o,
  output reg  [3:0] bass_level_o,
  output reg  [1:0] bass_corner_o,
  output reg        treble_boost_select_o,
  output reg  [3:0] treble_level_o,
  output reg  [1:0] treble_corner_o,
  output reg  [1:0] deemph_select_o,
  output reg  [1:0] deemph_active_o,
  output reg        limiter_enable_o,
  output reg        limiter_volume_only_o,
  output reg        dither_enable_o,
  output reg  [2:0] attack_code_o,
  output reg  [3:0] release_code_o,
  output reg  [1:0] input_format_o,
  output reg  [3:0] channel_mix_select_o,
  output reg  [1:0] left_source_o,
  output reg  [1:0] right_source_o,
  output reg        bridge_enable_o,
  output reg  [4:0] pcomp_o,
  output reg  [4:0] ncomp_o,
  output reg        auto_low_power_enable_o,
  output reg        pwm_high_speed_o,
  output reg        pwm_h_type_o,
  output reg  [3:0] pwm_mode_o,
  output reg        word_update_o,
  output reg        frame_error_o
);

  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_PRE  = 5'b00010;
  localparam [4:0] ST_WR   = 5'b00100;
  localparam [4:0] ST_RD   = 5'b01000;
  localparam [4:0] ST_SKIP = 5'b10000;

  wire [2:0]         link_sync;
  wire               en_active;
  wire               clk_s;
  wire               data_s;
  reg                clk_prev;
  wire               clk_rise;
  wire               clk_fall;
  reg  [4:0]         state;
  reg  [6:0]         bit_cnt;
  reg  [`PRE_W-1:0]  pre_shift;
  reg  [`WORD_W-1:0] rx_shift;
  reg  [`WORD_W-1:0] tx_shift;
  reg  [`WORD_W-1:0] ctrl_word;
  wire [`PRE_W-1:0]  pre_full;
  wire [`WORD_W-1:0] rx_full;
  wire [9:0]         left_gain;
  wire [9:0]         right_gain;
  wire               left_mute;
  wire               right_mute;
  // Keep a compensation field inside 00000..10000
  function [4:0] comp_limit;
    input [4:0] value;
    begin
      if (value > `COMP_MAX)
        comp_limit = `COMP_MAX;
      else
        comp_limit = value;
    end
  endfunction
  // Speed and method bits to one-hot operating mode
  function [3:0] pwm_decode;
    input hspd;
    input hpwm;
    begin
      case ({hspd, hpwm})
        2'b00:   pwm_decode = 4'h1;
        2'b01:   pwm_decode = 4'h2;
        2'b10:   pwm_decode = 4'h4;
        default: pwm_decode = 4'h8;
      endcase
    end
  endfunction
  link_sync
  #(
    .WIDTH (3)
  )
  u_sync
  (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({~link_en_n_i, link_clk_i, link_data_i}),
    .sync_o    (link_sync)
  );
  assign en_active = link_sync[2];
  assign clk_s     = link_sync[1];
  assign data_s    = link_sync[0];
  assign clk_rise  = clk_s & ~clk_prev;
  assign clk_fall  = ~clk_s & clk_prev;
  assign pre_full  = {pre_shift[`PRE_W-2:0], data_s};
  assign rx_full   = {rx_shift[`WORD_W-2:0], data_s};
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      clk_prev <= 1'b0;
    else
      clk_prev <= clk_s;
  end
  // Link frame sequencer; data sampled on rising link edges
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state          <= ST_IDLE;
      bit_cnt        <= 7'h00;
      pre_shift      <= {`PRE_W{1'b0}};
      rx_shift       <= {`WORD_W{1'b0}};
      tx_shift       <= {`WORD_W{1'b0}};
      ctrl_word      <= `CTRL_RESET;
      link_data_o    <= 1'b0;
      link_data_oe_o <= 1'b0;
      word_update_o  <= 1'b0;
      frame_error_o  <= 1'b0;
    end
    else
    begin
      word_update_o <= 1'b0;
      frame_error_o <= 1'b0;
      if (!en_active)
      begin
        // Enable released: abandon any partial word
        state          <= ST_IDLE;
        bit_cnt        <= 7'h00;
        link_data_oe_o <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE, ST_PRE:
          begin
            state <= ST_PRE;
            if (clk_rise)
            begin
              pre_shift <= pre_full;
              bit_cnt   <= bit_cnt + 7'h01;
              if (bit_cnt == 7'd7)
              begin
                bit_cnt <= 7'h00;
                if (pre_full[7:6] != 2'b00 ||
                    !pre_full[`PRE_MARK_BIT] ||
                    pre_full[`PRE_REF_LSB+3:`PRE_REF_LSB] != PART_REF)
                begin
                  state         <= ST_SKIP;
                  frame_error_o <= 1'b1;
                end
                else if (pre_full[`PRE_RW_BIT])
                begin
                  state    <= ST_RD;
                  tx_shift <= ctrl_word;
                end
                else
                  state <= ST_WR;
              end
            end
          end
          ST_WR:
          begin
            if (clk_rise)
            begin
              rx_shift <= rx_full;
              bit_cnt  <= bit_cnt + 7'h01;
              // RL23: commit whole word
              if (bit_cnt == 7'd63)
              begin
                state         <= ST_SKIP;
                word_update_o <= 1'b1;
                ctrl_word     <= rx_full;
                // RL11: clamp compensation
                ctrl_word[`PCOMP_LSB+4:`PCOMP_LSB] <=
                  comp_limit(rx_full[`PCOMP_LSB+4:`PCOMP_LSB]);
                ctrl_word[`NCOMP_LSB+4:`NCOMP_LSB] <=
                  comp_limit(rx_full[`NCOMP_LSB+4:`NCOMP_LSB]);
              end
            end
          end
          ST_RD:
          begin
            // Read-back driven on falling edges, MSB first
            if (clk_fall)
            begin
              if (bit_cnt == 7'd64)
              begin
                link_data_oe_o <= 1'b0;
                state          <= ST_SKIP;
              end
              else
              begin
                link_data_oe_o <= 1'b1;
                link_data_o    <= tx_shift[`WORD_W-1];
                tx_shift       <= {tx_shift[`WORD_W-2:0], 1'b0};
                bit_cnt        <= bit_cnt + 7'h01;
              end
            end
          end
          ST_SKIP:
          begin
            // Extra bits ignored until enable goes high
            link_data_oe_o <= 1'b0;
          end
          default:
          begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // RL15: gain mapping per channel
  volume_decode u_vol_left
  (
    .code_i         (ctrl_word[`VOL_L_LSB+8:`VOL_L_LSB]),
    .gain_half_db_o (left_gain),
    .soft_mute_o    (left_mute)
  );

  // RL17: same mapping for right
  volume_decode u_vol_right
  (
    .code_i         (ctrl_word[`VOL_R_LSB+8:`VOL_R_LSB]),
    .gain_half_db_o (right_gain),
    .soft_mute_o    (right_mute)
  );

  // Field outputs registered from the committed word, deemph_active_o also gated by speed_mode_i
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      left_volume_o           <= `VOL_RESET;
      right_volume_o          <= `VOL_RESET;
      left_gain_half_db_o     <= 10'h3FC;
      right_gain_half_db_o    <= 10'h3FC;
      left_soft_mute_o        <= 1'b0;
      right_soft_mute_o       <= 1'b0;
      bass_boost_select_o     <= 1'b0;
      bass_level_o            <= 4'h0;
      bass_corner_o           <= 2'h0;
      treble_boost_select_o   <= 1'b0;
      treble_level_o          <= 4'h0;
      treble_corner_o         <= 2'h0;
      deemph_select_o         <= 2'h0;
      deemph_active_o         <= 2'h0;
      limiter_enable_o        <= 1'b0;
      limiter_volume_only_o   <= 1'b0;
      dither_enable_o         <= 1'b0;
      attack_code_o           <= `ATTACK_RESET;
      release_code_o          <= `RELEASE_RESET;
      input_format_o          <= 2'h0;
      channel_mix_select_o    <= `MIX_RESET;
      left_source_o           <= 2'h2;
      right_source_o          <= 2'h1;
      bridge_enable_o         <= 1'b0;
      pcomp_o                 <= `PCOMP_RESET;
      ncomp_o                 <= `NCOMP_RESET;
      auto_low_power_enable_o <= 1'b0;
      pwm_high_speed_o        <= 1'b0;
      pwm_h_type_o            <= 1'b0;
      pwm_mode_o              <= 4'h1;
    end
    else
    begin
      // RL16: soft mute code and reset volume
      left_volume_o        <= ctrl_word[`VOL_L_LSB+8:`VOL_L_LSB];
      right_volume_o       <= ctrl_word[`VOL_R_LSB+8:`VOL_R_LSB];
      left_gain_half_db_o  <= left_gain;
      right_gain_half_db_o <= right_gain;
      left_soft_mute_o     <= left_mute;
      right_soft_mute_o    <= right_mute;
      // RL19: bass level and direction
      bass_boost_select_o  <= ctrl_word[`BASS_BOOST_BIT];
      bass_level_o         <= ctrl_word[`BASS_LVL_LSB+3:`BASS_LVL_LSB];
      // RL20: bass corner
      bass_corner_o <= ctrl_word[`BASS_CORNER_LSB+1:`BASS_CORNER_LSB];
      // RL21: treble level and direction
      treble_boost_select_o <= ctrl_word[`TREB_BOOST_BIT];
      treble_level_o <= ctrl_word[`TREB_LVL_LSB+3:`TREB_LVL_LSB];
      // RL22: treble corner
      treble_corner_o <= ctrl_word[`TREB_CORNER_LSB+1:`TREB_CORNER_LSB];
      // RL1: sample rate of de-emphasis
      deemph_select_o <= ctrl_word[`DEEMPH_LSB+1:`DEEMPH_LSB];
      // RL2: filter only at single speed
      if (speed_mode_i == `SPEED_SINGLE)
        deemph_active_o <= ctrl_word[`DEEMPH_LSB+1:`DEEMPH_LSB];
      else
        deemph_active_o <= 2'h0;
      // RL3: limiter enable
      limiter_enable_o <= ctrl_word[`LIMIT_EN_BIT];
      // RL4: limiter behaviour
      limiter_volume_only_o <= ctrl_word[`LIMIT_MODE_BIT];
      dither_enable_o <= ctrl_word[`DITHER_BIT];
      // RL5: attack rate code
      attack_code_o <= ctrl_word[`ATTACK_LSB+2:`ATTACK_LSB];
      // RL6: release rate code
      release_code_o <= ctrl_word[`RELEASE_LSB+3:`RELEASE_LSB];
      // RL7: audio input format
      input_format_o <= ctrl_word[`FORMAT_LSB+1:`FORMAT_LSB];
      // RL8: channel mix field
      channel_mix_select_o <= ctrl_word[`MIX_LSB+3:`MIX_LSB];
      // RL9: per-channel source split
      left_source_o  <= ctrl_word[`MIX_LSB+3:`MIX_LSB+2];
      right_source_o <= ctrl_word[`MIX_LSB+1:`MIX_LSB];
      // RL10: bridge drive gate
      bridge_enable_o <= ctrl_word[`BRIDGE_BIT];
      pcomp_o <= ctrl_word[`PCOMP_LSB+4:`PCOMP_LSB];
      ncomp_o <= ctrl_word[`NCOMP_LSB+4:`NCOMP_LSB];
      // RL12: auto low power
      auto_low_power_enable_o <= ctrl_word[`LOW_POWER_BIT];
      // RL13: speed and method bits
      pwm_high_speed_o <= ctrl_word[`SPEED_BIT];
      pwm_h_type_o     <= ctrl_word[`METHOD_BIT];
      // RL14: operating mode decode
      pwm_mode_o <= pwm_decode(ctrl_word[`SPEED_BIT],
                               ctrl_word[`METHOD_BIT]);
    end
  end

endmodule

// >>> host_link_model.sv
`timescale 1ns/1ns
module host_link_model
#(
  parameter int HALF = 80
)
(
  input  wire logic dut_data_i,
  input  wire logic dut_oe_i,
  output logic      link_en_n_o,
  output logic      link_clk_o,
  output logic      line_o
);
  logic        host_d = 1'b1;
  logic [63:0] rd_word;
  event        rd_done;
  // During read data bits the released line shows a changing level, never a stale one
  assign line_o = dut_oe_i ? dut_data_i : host_d;
  initial
  begin
    link_en_n_o = 1'b1;
    link_clk_o = 1'b0;
  end
  task automatic frame(input logic rw, input logic [3:0] pref,
                       input logic [63:0] wd, input int nb);
    logic [71:0] sh;
    sh = {3'b001, pref, rw, wd};
    link_en_n_o = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      host_d = (rw && i > 7) ? ~host_d : sh[71-i];
      #(HALF);
      link_clk_o = 1'b1;
      if (rw && i > 7)
        rd_word = {rd_word[62:0], line_o};
      #(HALF);
      link_clk_o = 1'b0;
    end
    #(HALF);
    // Long idle gap keeps the enable high well past three clocks
    link_en_n_o = 1'b1;
    #(4*HALF);
    if (rw && nb == 72)
      -> rd_done;
  endtask
endmodule

// >>> link_sync.v
`timescale 1ns/1ns
module link_sync
#(
  parameter WIDTH = 3
)
(
  input  wire             sys_clk_i,
  input  wire             resetn_i,
  input  wire [WIDTH-1:0] async_i,
  output reg  [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1;

  // Stage one feeds stage two only
  always @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      stage1 <= {WIDTH{1'b0}};
      sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // Arbitrary reference code
  localparam logic [3:0]  REF = 4'h5;
  localparam logic [63:0] RST = 64'h0082_4A20_0001_F4FA;
  logic        sys_clk_i, resetn_i, link_en_n_i, link_clk_i, link_data_i;
  logic        link_data_o, link_data_oe_o, word_update_o, frame_error_o;
  logic [1:0]  speed_mode_i, bass_corner_o, treble_corner_o, input_format_o;
  logic [1:0]  deemph_select_o, deemph_active_o, left_source_o;
  logic [1:0]  right_source_o;
  logic [8:0]  left_volume_o, right_volume_o, v;
  logic [9:0]  left_gain_half_db_o, right_gain_half_db_o;
  logic [3:0]  bass_level_o, treble_level_o, release_code_o, pwm_mode_o;
  logic [3:0]  channel_mix_select_o;
  logic [4:0]  pcomp_o, ncomp_o;
  logic [2:0]  attack_code_o;
  logic        left_soft_mute_o, right_soft_mute_o, bass_boost_select_o;
  logic        treble_boost_select_o, limiter_enable_o, limiter_volume_only_o;
  logic        dither_enable_o, bridge_enable_o, auto_low_power_enable_o;
  logic        pwm_high_speed_o, pwm_h_type_o;
  logic [63:0] wq[$], rq[$], cur, ew, w;
  int          num_errors, checks_done, err_seen, seed;

  amp_ctrl_regs #(.PART_REF(REF)) DUT (.*);
  host_link_model host (.dut_data_i(link_data_o), .dut_oe_i(link_data_oe_o),
    .link_en_n_o(link_en_n_i), .link_clk_o(link_clk_i),
    .line_o(link_data_i));

  function automatic logic [63:0] obs();
    return {pwm_h_type_o, pwm_high_speed_o, auto_low_power_enable_o,
      ncomp_o, pcomp_o, bridge_enable_o, channel_mix_select_o,
      input_format_o, release_code_o, attack_code_o, dither_enable_o,
      limiter_volume_only_o, limiter_enable_o, deemph_select_o,
      treble_corner_o, treble_level_o, treble_boost_select_o, bass_corner_o,
      bass_level_o, bass_boost_select_o, right_volume_o, left_volume_o};
  endfunction
  function automatic logic [9:0] gain(input logic [8:0] c);
    if (c <= 9'h040)
      return 10'h342;
    if (c >= 9'h130)
      return 10'h032;
    return {1'b0, c} - 10'h0FE;
  endfunction
  function automatic logic [4:0] cl(input logic [4:0] x);
    return (x > 5'h10) ? 5'h10 : x;
  endfunction
  task automatic bad(input string msg);
    $display("BAD %0t %s", $time, msg);
    num_errors++;
  endtask
  task automatic chk64(input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
      bad($sformatf("word exp %h got %h", e, g));
  endtask
  task automatic chk10(input logic [9:0] e, input logic [9:0] g);
    checks_done++;
    if (g !== e)
      bad($sformatf("gain exp %h got %h", e, g));
  endtask
  task automatic wr(input logic [63:0] x);
    cur = x;
    cur[55:51] = cl(x[55:51]);
    cur[60:56] = cl(x[60:56]);
    wq.push_back(cur);
    host.frame(1'b0, REF, x, 72);
  endtask
  task automatic rb();
    rq.push_back(cur);
    host.frame(1'b1, REF, 64'h0, 72);
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #500_000;
    bad("timeout");
    close_out();
  end
  always @(posedge sys_clk_i)
  begin
    #1;
    if (frame_error_o === 1'b1)
      err_seen++;
    if (word_update_o === 1'b1)
    begin
      @(posedge sys_clk_i);
      #1;
      if (wq.size() == 0)
        bad("unexpected update");
      else
      begin
        ew = wq.pop_front();
        chk64(ew, obs());
        chk10(gain(ew[8:0]), left_gain_half_db_o);
        chk10(gain(ew[17:9]), right_gain_half_db_o);
      end
    end
  end
  always @(host.rd_done)
    chk64(rq.pop_front(), host.rd_word);

  initial
  begin
    seed = 2490;
    resetn_i = 1'b0;
    speed_mode_i = 2'h0;
    repeat (10) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk64(RST, obs());
    cur = RST;
    rb();
    for (int i = 0; i < 8; i++)
    begin
      w = {$random(seed), $random(seed)};
      w[33:32] = i[1:0];
      w[45:44] = i[1:0];
      w[63:62] = i[1:0];
      if (i == 0)
        w[60:51] = {5'h10, 5'h11};
      speed_mode_i = {i[2], i[2] & i[0]};
      wr(w);
      rb();
    end
    for (int c = 0; c < 6; c++)
    begin
      v = (c < 3) ? 9'h12E + c : 9'h045 - c;
      wr({cur[63:18], v, v});
    end
    host.frame(1'b0, ~REF, {$random(seed), $random(seed)}, 72);
    host.frame(1'b0, REF, {$random(seed), $random(seed)}, 40);
    rb();
    chk64(64'h1, 64'(err_seen));
    resetn_i = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1 resetn_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    chk64(RST, obs());
    cur = RST;
    rb();
    repeat (4) @(posedge sys_clk_i);
    if (wq.size() != 0 || rq.size() != 0)
      bad("results missing");
    close_out();
  end
endmodule

// >>> volume_decode.v
`timescale 1ns/1ns
`include "amp_ctrl_defs.vh"
module volume_decode
(
  input  wire [8:0] code_i,
  output reg  [9:0] gain_half_db_o,
  output reg        soft_mute_o
);

  // Signed gain in 0.5 dB units, 0 dB at code 0FE
  always @*
  begin
    soft_mute_o = (code_i <= `VOL_SOFT_MUTE);
    if (code_i <= `VOL_SOFT_MUTE)
      gain_half_db_o = {1'b0, `VOL_SOFT_MUTE} - {1'b0, `VOL_0DB};
    else if (code_i >= `VOL_MAX)
      // Codes above +25 dB saturate
      gain_half_db_o = {1'b0, `VOL_MAX} - {1'b0, `VOL_0DB};
    else
      gain_half_db_o = {1'b0, code_i} - {1'b0, `VOL_0DB};
  end

endmodule
